// ---- oamd_decoder.sv ----
// operand address mode decoder top: fetch sequencer and address forming
// Contract
// [RULE_01] seventeen addressing modes grouped into seven families.
// [RULE_02] inherent instructions are one byte; nothing is fetched after opcode.
// [RULE_03] immediate is opcode plus one operand value byte.
// [RULE_04] short direct fetches one address byte, page zero only.
// [RULE_05] long direct fetches a two-byte address word.
// [RULE_06] indexed address is unsigned index plus mode offset.
// [RULE_07] indexed without offset fetches nothing; address is the index.
// [RULE_08] short indexed adds one offset byte, reaching up to 1fe.
// [RULE_09] long indexed adds index to a two-byte offset word.
// [RULE_10] short indirect reads a byte pointer from page zero.
// [RULE_11] long indirect forms read a word pointer via one byte.
// [RULE_12] indirect indexed adds index to pointer read from memory.
// [RULE_13] short indirect indexed reaches 00 to 1fe.
// [RULE_14] short forms take a page-zero base, indexed sums reach 1fe; long forms need more bytes.
// [RULE_15] read-modify-write instructions accept short forms only.
// [RULE_16] mask set raises level to 3, mask clear lowers to 0.
// [RULE_17] relative target adds signed 8-bit offset to program counter.
// [RULE_18] lower-address byte of a word is the high byte.
// [RULE_19] short indexed sums are nine bits wide, no wrap.
`timescale 1ns/1ps
module oamd_decoder (
   input  wire logic                   core_clk,
   input  wire logic                   srst,
   input  wire logic                   dec_start,
   input  wire oamd_pkg::oamd_mode_t   dec_mode,
   input  wire logic [15:0]            dec_pc,
   input  wire logic [7:0]             dec_index,
   input  wire logic                   dec_rmw,
   input  wire oamd_pkg::oamd_mask_op_t dec_mask_op,
   output logic                        dec_busy,
   output logic                        mem_rd_req,
   output logic [15:0]                 mem_rd_addr,
   input  wire logic [7:0]             mem_rd_data,
   input  wire logic                   mem_rd_ack,
   output logic                        dec_done,
   output logic                        dec_refused,
   output oamd_pkg::oamd_family_t      dec_family,
   output logic [15:0]                 dec_ea,
   output logic [7:0]                  dec_imm,
   output logic [2:0]                  dec_len,
   output logic                        dec_branch,
   output logic [15:0]                 dec_target,
   output logic [1:0]                  mask_level
);
   import oamd_pkg::*;

   // ********************************
   // declarations
   // ********************************
   oamd_state_t   state_r;
   oamd_state_t   state_nxt;
   oamd_mode_t    mode_r;
   oamd_mode_t    t_mode;
   oamd_family_t  t_fam;
   logic [1:0]    t_nb;
   logic          t_ind;
   logic          t_ptrw;
   logic          t_idx;
   logic          t_rel;
   logic          t_bitrel;
   logic          t_imm;
   logic          t_long;
   logic [15:0]   pc_r;
   logic [7:0]    index_r;
   logic          refuse_r;
   logic [7:0]    b1_r;
   logic [7:0]    b2_r;
   logic [7:0]    p1_r;
   logic [7:0]    p2_r;
   logic [15:0]   addr_r;
   logic [15:0]   addr_nxt;
   logic          start_ok;
   logic          rd_take;
   logic [15:0]   base;
   logic [7:0]    offset;
   logic [2:0]    len;
   logic [15:0]   sum_ea;
   logic [15:0]   sum_target;
   logic          done_r;
   logic          refused_r;
   oamd_family_t  family_r;
   logic [15:0]   ea_r;
   logic [7:0]    imm_r;
   logic [2:0]    len_r;
   logic          branch_r;
   logic [15:0]   target_r;
   logic [1:0]    mask_level_r;

   // ********************************
   // handshakes
   // ********************************
   assign dec_busy   = (state_r != ST_IDLE);
   assign start_ok   = dec_start && (state_r == ST_IDLE);
   assign mem_rd_req = (state_r == ST_OPR1) || (state_r == ST_OPR2) ||
                       (state_r == ST_PTR1) || (state_r == ST_PTR2);
   assign rd_take    = mem_rd_req && mem_rd_ack;
   assign mem_rd_addr = addr_r;

   // ********************************
   // mode properties
   // ********************************
   assign t_mode = (state_r == ST_IDLE) ? dec_mode : mode_r;

   oamd_mode_table u_table (
      .mode      (t_mode),
      .fam       (t_fam),
      .nb        (t_nb),
      .ind       (t_ind),
      .ptrw      (t_ptrw),
      .idx       (t_idx),
      .rel       (t_rel),
      .bitrel    (t_bitrel),
      .imm       (t_imm),
      .long_form (t_long)
   );

   // ********************************
   // fetch sequencer
   // ********************************
   always_comb begin
      state_nxt = state_r;
      addr_nxt  = addr_r;
      case (state_r)
         ST_IDLE: begin
            if (start_ok) begin
               // [RULE_15] long form refused for rmw
               if ((dec_rmw && t_long) || (t_nb == 2'h0)) begin
                  state_nxt = ST_DONE;
               end else begin
                  state_nxt = ST_OPR1;
                  addr_nxt  = dec_pc + STEP_ONE;
               end
            end
         end
         ST_OPR1: begin
            if (rd_take) begin
               // [RULE_10] pointer lives in page zero
               if (t_ind) begin
                  state_nxt = ST_PTR1;
                  addr_nxt  = {PAGE_ZERO_HI, mem_rd_data};
               end else if (t_nb == 2'h2) begin
                  state_nxt = ST_OPR2;
                  addr_nxt  = pc_r + STEP_TWO;
               end else begin
                  state_nxt = ST_DONE;
               end
            end
         end
         ST_PTR1: begin
            if (rd_take) begin
               // [RULE_11] word pointer needs second read
               if (t_ptrw) begin
                  state_nxt = ST_PTR2;
                  addr_nxt  = addr_r + STEP_ONE;
               end else if (t_bitrel) begin
                  state_nxt = ST_OPR2;
                  addr_nxt  = pc_r + STEP_TWO;
               end else begin
                  state_nxt = ST_DONE;
               end
            end
         end
         ST_OPR2, ST_PTR2: begin
            if (rd_take) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         addr_r  <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         addr_r  <= addr_nxt;
      end
   end

   // ********************************
   // instruction context
   // ********************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mode_r   <= AM_INH;
         pc_r     <= 16'h0000;
         index_r  <= 8'h00;
         refuse_r <= 1'b0;
      end else if (start_ok) begin
         mode_r   <= dec_mode;
         pc_r     <= dec_pc;
         index_r  <= dec_index;
         refuse_r <= dec_rmw && t_long;
      end
   end

   // ********************************
   // fetched bytes
   // ********************************
   always_ff @(posedge core_clk) begin
      if (srst || start_ok) begin
         b1_r <= 8'h00;
         b2_r <= 8'h00;
         p1_r <= 8'h00;
         p2_r <= 8'h00;
      end else if (rd_take) begin
         if (state_r == ST_OPR1) b1_r <= mem_rd_data;
         if (state_r == ST_OPR2) b2_r <= mem_rd_data;
         if (state_r == ST_PTR1) p1_r <= mem_rd_data;
         if (state_r == ST_PTR2) p2_r <= mem_rd_data;
      end
   end

   // ********************************
   // address forming
   // ********************************
   // [RULE_18] first byte is high byte
   always_comb begin
      if (t_ind) begin
         base = t_ptrw ? {p1_r, p2_r} : {PAGE_ZERO_HI, p1_r};
      end else if ((t_nb == 2'h2) && !t_bitrel) begin
         base = {b1_r, b2_r};
      end else begin
         // [RULE_14] short forms in page zero
         base = {PAGE_ZERO_HI, b1_r};
      end
   end

   assign offset = t_bitrel ? b2_r : (t_ind ? p1_r : b1_r);
   assign len    = LEN_OPCODE + {1'b0, t_nb};

   oamd_ea_adder u_adder (
      .base   (base),
      .index  (index_r),
      .idx_en (t_idx),
      .pc     (pc_r),
      .len    (len),
      .offset (offset),
      .ea     (sum_ea),
      .target (sum_target)
   );

   // ********************************
   // result registers
   // ********************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         done_r    <= 1'b0;
         refused_r <= 1'b0;
         family_r  <= FAM_INHERENT;
         ea_r      <= 16'h0000;
         imm_r     <= 8'h00;
         len_r     <= LEN_OPCODE;
         branch_r  <= 1'b0;
         target_r  <= 16'h0000;
      end else begin
         done_r <= (state_r == ST_DONE);
         if (state_r == ST_DONE) begin
            refused_r <= refuse_r;
            family_r  <= t_fam;
            ea_r      <= refuse_r ? 16'h0000 : sum_ea;
            imm_r     <= t_imm ? b1_r : 8'h00;
            len_r     <= len;
            branch_r  <= !refuse_r && (t_rel || t_bitrel);
            target_r  <= sum_target;
         end
      end
   end

   assign dec_done    = done_r;
   assign dec_refused = refused_r;
   assign dec_family  = family_r;
   assign dec_ea      = ea_r;
   assign dec_imm     = imm_r;
   assign dec_len     = len_r;
   assign dec_branch  = branch_r;
   assign dec_target  = target_r;

   // ********************************
   // interrupt mask level
   // ********************************
   // [RULE_16] set and clear on inherent start
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mask_level_r <= MASK_LVL_RST;
      end else if (start_ok && (dec_mode == AM_INH)) begin
         if (dec_mask_op == MASK_OP_SET) mask_level_r <= MASK_LVL_SET;
         else if (dec_mask_op == MASK_OP_CLEAR) mask_level_r <= MASK_LVL_CLEAR;
      end
   end

   assign mask_level = mask_level_r;

   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_start(oamd_mode_t m);
      start_ok && (dec_mode == m);
   endsequence

   sequence s_quiet_done;
      !mem_rd_req ##1 dec_done;
   endsequence

   AST_INH_ONE_BYTE: assert property ( // [RULE_02]
      s_start(AM_INH) |=> s_quiet_done ##0 (dec_len == 3'h1)
   ) else $error("inherent form fetched bytes or wrong length");

   AST_IMM_TWO_BYTES: assert property ( // [RULE_03]
      dec_done && (dec_family == FAM_IMMEDIATE) |-> (dec_len == 3'h2) && (dec_imm == b1_r)
   ) else $error("immediate form length or value wrong");

   AST_FIRST_FETCH_ADDR: assert property ( // [RULE_04]
      start_ok && !dec_rmw && (dec_mode == AM_DIR_S) |=> mem_rd_req && (mem_rd_addr == $past(dec_pc) + 16'h0001)
   ) else $error("first operand byte not read after opcode");

   AST_SHORT_DIR_PAGE0: assert property ( // [RULE_14]
      dec_done && (mode_r == AM_DIR_S) |-> (dec_ea == {8'h00, b1_r}) && (dec_len == 3'h2)
   ) else $error("short direct address left page zero");

   AST_LONG_DIR_WORD: assert property ( // [RULE_05]
      dec_done && !dec_refused && (mode_r == AM_DIR_L) |-> (dec_ea == {b1_r, b2_r}) && (dec_len == 3'h3)
   ) else $error("long direct address word wrong");

   AST_IDX_NO_OFFSET: assert property ( // [RULE_07]
      s_start(AM_IDX_0) |=> s_quiet_done ##0 (dec_ea == {8'h00, index_r})
   ) else $error("no-offset indexed address wrong");

   AST_IDX_SHORT_SUM: assert property ( // [RULE_08]
      dec_done && (mode_r == AM_IDX_S) |-> (dec_ea == 16'({8'h00, b1_r}) + 16'(index_r)) && (dec_ea <= 16'h01fe)
   ) else $error("short indexed sum wrong");

   AST_IDX_LONG_SUM: assert property ( // [RULE_09]
      dec_done && !dec_refused && (mode_r == AM_IDX_L) |-> dec_ea == {b1_r, b2_r} + 16'(index_r)
   ) else $error("long indexed sum wrong");

   AST_PTR_FROM_PAGE0: assert property ( // [RULE_10]
      (state_r == ST_OPR1) && rd_take && t_ind |=> (state_r == ST_PTR1) && (mem_rd_addr == {8'h00, $past(mem_rd_data)})
   ) else $error("pointer not read from page zero");

   AST_LONG_PTR_WORD: assert property ( // [RULE_11]
      dec_done && !dec_refused && (mode_r == AM_IND_L) |-> dec_ea == {p1_r, p2_r}
   ) else $error("long indirect pointer word wrong");

   AST_IIX_SHORT_SUM: assert property ( // [RULE_13]
      dec_done && (mode_r == AM_IIX_S) |-> (dec_ea == 16'({8'h00, p1_r}) + 16'(index_r)) && (dec_ea <= 16'h01fe)
   ) else $error("short indirect indexed sum wrong");

   AST_RMW_LONG_REFUSED: assert property ( // [RULE_15]
      start_ok && dec_rmw && t_long |=> s_quiet_done ##0 dec_refused
   ) else $error("long form accepted for read-modify-write");

   AST_MASK_SET: assert property ( // [RULE_16]
      s_start(AM_INH) ##0 (dec_mask_op == MASK_OP_SET) |=> (mask_level == 2'h3)
   ) else $error("mask set did not reach level 3");

   AST_MASK_CLEAR: assert property ( // [RULE_16]
      s_start(AM_INH) ##0 (dec_mask_op == MASK_OP_CLEAR) |=> (mask_level == 2'h0)
   ) else $error("mask clear did not reach level 0");

   AST_REL_TARGET: assert property ( // [RULE_17]
      dec_done && (mode_r == AM_REL_D) |-> dec_branch && (dec_target == pc_r + 16'h0002 + {{8{b1_r[7]}}, b1_r})
   ) else $error("relative branch target wrong");

endmodule // oamd_decoder

// ---- oamd_decoder_tb.sv ----
// self-checking bench for the operand address mode decoder
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module oamd_decoder_tb;
   import oamd_pkg::*;
   logic          core_clk, srst, dec_start, dec_rmw, dec_busy, mem_rd_req, mem_rd_ack;
   logic          dec_done, dec_refused, dec_branch;
   oamd_mode_t    dec_mode;
   oamd_mask_op_t dec_mask_op;
   oamd_family_t  dec_family;
   logic [15:0]   dec_pc, mem_rd_addr, dec_ea, dec_target;
   logic [7:0]    dec_index, mem_rd_data, dec_imm;
   logic [2:0]    dec_len;
   logic [1:0]    mask_level;
   logic [3:0]    lat;
   int            fails, comparisons, nrd, cyc;

   oamd_decoder i_dut (.core_clk, .srst, .dec_start, .dec_mode, .dec_pc, .dec_index, .dec_rmw,
      .dec_mask_op, .dec_busy, .mem_rd_req, .mem_rd_addr, .mem_rd_data, .mem_rd_ack, .dec_done,
      .dec_refused, .dec_family, .dec_ea, .dec_imm, .dec_len, .dec_branch, .dec_target, .mask_level);
   oamd_mem_model i_mem (.core_clk, .mem_rd_req, .mem_rd_addr, .lat, .mem_rd_data, .mem_rd_ack);

   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (mem_rd_req && mem_rd_ack) nrd++;
   end

   // ********************************
   // shared tasks
   // ********************************
   task automatic wrap_up();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_mem.mem[a] = d;
   endtask

   task automatic do_op(input oamd_mode_t m, input logic [15:0] pc, input logic [7:0] ix = 8'h00,
                        input logic rmw = 1'b0, input oamd_mask_op_t mo = MASK_OP_NONE);
      int n;
      dec_mode = m;
      dec_pc = pc;
      dec_index = ix;
      dec_rmw = rmw;
      dec_mask_op = mo;
      dec_start = 1'b1;
      nrd = 0;
      @(posedge core_clk);
      #1;
      dec_start = 1'b0;
      n = 0;
      while (dec_done !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      cyc = n + 1;
      if (n >= 200) begin
         fails++;
         wrap_up();
      end
   endtask

   task automatic lchk(input oamd_family_t f, input logic [2:0] len, input int rd);
      `CHK(dec_family, f)
      `CHK(dec_len, len)
      `CHK(nrd, rd)
   endtask

   task automatic chk(input oamd_family_t f, input logic [15:0] ea, input logic [2:0] len, input int rd);
      lchk(f, len, rd);
      `CHK(dec_ea, ea)
   endtask

   task automatic br(input logic b, input logic [15:0] t);
      `CHK(dec_branch, b)
      if (b) `CHK(dec_target, t)
   endtask

   // ********************************
   // scenarios
   // ********************************
   task automatic t_inherent();
      `CHK(mask_level, MASK_LVL_RST)
      `CHK(dec_len, 3'h1)
      do_op(AM_INH, 16'h0100, 8'h00, 1'b0, MASK_OP_CLEAR);
      `CHK(mask_level, 2'h0)
      `CHK(cyc, 2)
      lchk(FAM_INHERENT, 3'h1, 0);
      do_op(AM_INH, 16'h0100, 8'h00, 1'b0, MASK_OP_SET);
      `CHK(mask_level, 2'h3)
      do_op(AM_IMM, 16'h0100, 8'h00, 1'b0, MASK_OP_CLEAR);
      `CHK(mask_level, 2'h3)
      `CHK(dec_imm, 8'h5b)
      lchk(FAM_IMMEDIATE, 3'h2, 1);
   endtask

   task automatic t_direct();
      wr(16'h2001, 8'h80);
      do_op(AM_DIR_S, 16'h2000);
      chk(FAM_DIRECT, 16'h0080, 3'h2, 1);
      wr(16'h2001, 8'h12);
      wr(16'h2002, 8'h34);
      do_op(AM_DIR_L, 16'h2000);
      chk(FAM_DIRECT, 16'h1234, 3'h3, 2);
      `CHK(cyc, 4)
   endtask

   task automatic t_indexed();
      do_op(AM_IDX_0, 16'h4000, 8'hff);
      chk(FAM_INDEXED, 16'h00ff, 3'h1, 0);
      wr(16'h4001, 8'hff);
      do_op(AM_IDX_S, 16'h4000, 8'hff);
      chk(FAM_INDEXED, 16'h01fe, 3'h2, 1);
      wr(16'h4002, 8'hf0);
      do_op(AM_IDX_L, 16'h4000, 8'h0f);
      chk(FAM_INDEXED, 16'hffff, 3'h3, 2);
   endtask

   task automatic t_indirect();
      wr(16'h5001, 8'h40);
      wr(16'h0040, 8'h77);
      wr(16'h0041, 8'hcd);
      do_op(AM_IND_S, 16'h5000, 8'h33);
      chk(FAM_INDIRECT, 16'h0077, 3'h2, 2);
      do_op(AM_IND_L, 16'h5000, 8'h33);
      chk(FAM_INDIRECT, 16'h77cd, 3'h2, 3);
      wr(16'h0040, 8'hff);
      do_op(AM_IIX_S, 16'h5000, 8'hff);
      chk(FAM_INDIRECT, 16'h01fe, 3'h2, 2);
      do_op(AM_IIX_L, 16'h5000, 8'h02);
      chk(FAM_INDIRECT, 16'hffcf, 3'h2, 3);
   endtask

   task automatic t_relative();
      wr(16'h3001, 8'h80);
      do_op(AM_REL_D, 16'h3000);
      lchk(FAM_RELATIVE, 3'h2, 1);
      br(1'b1, 16'h2f82);
      wr(16'h3001, 8'h20);
      wr(16'h0020, 8'h7f);
      do_op(AM_REL_I, 16'h3000);
      lchk(FAM_RELATIVE, 3'h2, 2);
      br(1'b1, 16'h3081);
      wr(16'h3002, 8'hfe);
      do_op(AM_BITR_D, 16'h3000);
      chk(FAM_BIT, 16'h0020, 3'h3, 2);
      br(1'b1, 16'h3001);
      do_op(AM_BITR_I, 16'h3000);
      chk(FAM_BIT, 16'h007f, 3'h3, 3);
      br(1'b1, 16'h3001);
      do_op(AM_BIT_D, 16'h3000);
      chk(FAM_BIT, 16'h0020, 3'h2, 1);
      br(1'b0, 16'h0000);
      do_op(AM_BIT_I, 16'h3000);
      chk(FAM_BIT, 16'h007f, 3'h2, 2);
   endtask

   task automatic t_rmw();
      oamd_mode_t lm[4] = '{AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIX_L};
      foreach (lm[i]) begin
         do_op(lm[i], 16'h6000, 8'h01, 1'b1);
         `CHK(dec_refused, 1'b1)
         `CHK(dec_ea, 16'h0000)
         `CHK(nrd, 0)
         `CHK(cyc, 2)
      end
      wr(16'h6001, 8'h33);
      do_op(AM_DIR_S, 16'h6000, 8'h01, 1'b1);
      `CHK(dec_refused, 1'b0)
      chk(FAM_DIRECT, 16'h0033, 3'h2, 1);
   endtask

   task automatic t_slow();
      lat = 4'h3;
      wr(16'h7001, 8'hab);
      wr(16'h7002, 8'hcd);
      do_op(AM_DIR_L, 16'h7000);
      chk(FAM_DIRECT, 16'habcd, 3'h3, 2);
      `CHK(cyc, 10)
      `CHK(dec_busy, 1'b0)
      @(posedge core_clk);
      #1;
      `CHK(dec_done, 1'b0)
      lat = 4'h0;
   endtask

   initial begin
      srst = 1'b1;
      dec_start = 1'b0;
      dec_mode = AM_INH;
      dec_pc = 16'h0000;
      dec_index = 8'h00;
      dec_rmw = 1'b0;
      dec_mask_op = MASK_OP_NONE;
      lat = 4'h0;
      fails = 0;
      comparisons = 0;
      nrd = 0;
      cyc = 0;
      repeat (20) @(posedge core_clk);
      #1;
      srst = 1'b0;
      @(posedge core_clk);
      #1;
      t_inherent();
      t_direct();
      t_indexed();
      t_indirect();
      t_relative();
      t_rmw();
      t_slow();
      wrap_up();
   end
endmodule // oamd_decoder_tb

// ---- oamd_ea_adder.sv ----
// effective address and branch target arithmetic
`timescale 1ns/1ps
module oamd_ea_adder (
   input  wire logic [15:0] base,
   input  wire logic [7:0]  index,
   input  wire logic        idx_en,
   input  wire logic [15:0] pc,
   input  wire logic [2:0]  len,
   input  wire logic [7:0]  offset,
   output logic      [15:0] ea,
   output logic      [15:0] target
);
   import oamd_pkg::*;

   logic [7:0] index_sel;

   // [RULE_06] unsigned index add
   // [RULE_12] pointer plus index
   assign index_sel = idx_en ? index : 8'h00;
   // [RULE_19] carry into bit 8 kept
   assign ea = base + {8'h00, index_sel};

   // [RULE_17] signed offset from next pc
   assign target = pc + {13'h0000, len} + {{8{offset[7]}}, offset};

endmodule // oamd_ea_adder

// ---- oamd_mem_model.sv ----
// memory partner model answering the decoder byte reads
`timescale 1ns/1ps
module oamd_mem_model (
   input  wire logic        core_clk,
   input  wire logic        mem_rd_req,
   input  wire logic [15:0] mem_rd_addr,
   input  wire logic [3:0]  lat,
   output logic      [7:0]  mem_rd_data,
   output logic             mem_rd_ack
);
   logic [7:0] mem [0:65535];
   int         wait_cnt;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h5a ^ i[7:0];
      end
      mem_rd_ack = 1'b0;
      mem_rd_data = 8'h00;
      wait_cnt = 0;
   end

   // ********************************
   // answer after lat idle cycles
   // ********************************
   // data toggles whenever not acknowledged, so stale bytes never look valid
   always @(posedge core_clk) begin
      #1;
      if (mem_rd_req && wait_cnt >= int'(lat)) begin
         mem_rd_ack = 1'b1;
         mem_rd_data = mem[mem_rd_addr];
         wait_cnt = 0;
      end else begin
         mem_rd_ack = 1'b0;
         mem_rd_data = ~mem_rd_data;
         wait_cnt = mem_rd_req ? wait_cnt + 1 : 0;
      end
   end
endmodule // oamd_mem_model

// ---- oamd_mode_table.sv ----
// per-mode properties of the operand addressing modes
`timescale 1ns/1ps
module oamd_mode_table (
   input  wire oamd_pkg::oamd_mode_t   mode,
   output oamd_pkg::oamd_family_t      fam,
   output logic [1:0]                  nb,
   output logic                        ind,
   output logic                        ptrw,
   output logic                        idx,
   output logic                        rel,
   output logic                        bitrel,
   output logic                        imm,
   output logic                        long_form
);
   import oamd_pkg::*;

   // [RULE_01] seventeen modes, seven families
   always_comb begin
      fam = FAM_INHERENT;
      {nb, ind, ptrw, idx, rel, bitrel, imm, long_form} = 9'h000;
      case (mode)
         AM_INH:    fam = FAM_INHERENT;
         AM_IMM:    begin fam = FAM_IMMEDIATE; nb = 2'h1; imm = 1'b1; end
         AM_DIR_S:  begin fam = FAM_DIRECT; nb = 2'h1; end
         AM_DIR_L:  begin fam = FAM_DIRECT; nb = 2'h2; long_form = 1'b1; end
         AM_IDX_0:  begin fam = FAM_INDEXED; idx = 1'b1; end
         AM_IDX_S:  begin fam = FAM_INDEXED; nb = 2'h1; idx = 1'b1; end
         AM_IDX_L:  begin fam = FAM_INDEXED; nb = 2'h2; idx = 1'b1; long_form = 1'b1; end
         AM_IND_S:  begin fam = FAM_INDIRECT; nb = 2'h1; ind = 1'b1; end
         AM_IND_L:  begin fam = FAM_INDIRECT; nb = 2'h1; ind = 1'b1; ptrw = 1'b1; long_form = 1'b1; end
         AM_IIX_S:  begin fam = FAM_INDIRECT; nb = 2'h1; ind = 1'b1; idx = 1'b1; end
         AM_IIX_L:  begin
            fam = FAM_INDIRECT; nb = 2'h1; ind = 1'b1; ptrw = 1'b1; idx = 1'b1; long_form = 1'b1;
         end
         AM_REL_D:  begin fam = FAM_RELATIVE; nb = 2'h1; rel = 1'b1; end
         AM_REL_I:  begin fam = FAM_RELATIVE; nb = 2'h1; ind = 1'b1; rel = 1'b1; end
         AM_BIT_D:  begin fam = FAM_BIT; nb = 2'h1; end
         AM_BIT_I:  begin fam = FAM_BIT; nb = 2'h1; ind = 1'b1; end
         AM_BITR_D: begin fam = FAM_BIT; nb = 2'h2; bitrel = 1'b1; end
         AM_BITR_I: begin fam = FAM_BIT; nb = 2'h2; ind = 1'b1; bitrel = 1'b1; end
         default:   fam = FAM_INHERENT;
      endcase
   end

endmodule // oamd_mode_table

// ---- oamd_pkg.sv ----
// shared types and constants of the operand address mode decoder
package oamd_pkg;

   // ********************************
   // widths and counts
   // ********************************
   localparam int ADDR_W       = 16;
   localparam int DATA_W       = 8;
   localparam int MODE_COUNT   = 17;
   localparam int FAMILY_COUNT = 7;

   // ********************************
   // addressing modes and families
   // ********************************
   typedef enum logic [4:0] {
      AM_INH    = 5'h00,
      AM_IMM    = 5'h01,
      AM_DIR_S  = 5'h02,
      AM_DIR_L  = 5'h03,
      AM_IDX_0  = 5'h04,
      AM_IDX_S  = 5'h05,
      AM_IDX_L  = 5'h06,
      AM_IND_S  = 5'h07,
      AM_IND_L  = 5'h08,
      AM_IIX_S  = 5'h09,
      AM_IIX_L  = 5'h0a,
      AM_REL_D  = 5'h0b,
      AM_REL_I  = 5'h0c,
      AM_BIT_D  = 5'h0d,
      AM_BIT_I  = 5'h0e,
      AM_BITR_D = 5'h0f,
      AM_BITR_I = 5'h10
   } oamd_mode_t;

   typedef enum logic [2:0] {
      FAM_INHERENT  = 3'h0,
      FAM_IMMEDIATE = 3'h1,
      FAM_DIRECT    = 3'h2,
      FAM_INDEXED   = 3'h3,
      FAM_INDIRECT  = 3'h4,
      FAM_RELATIVE  = 3'h5,
      FAM_BIT       = 3'h6
   } oamd_family_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_OPR1 = 3'h1,
      ST_OPR2 = 3'h2,
      ST_PTR1 = 3'h3,
      ST_PTR2 = 3'h4,
      ST_DONE = 3'h5
   } oamd_state_t;

   typedef enum logic [1:0] {
      MASK_OP_NONE  = 2'h0,
      MASK_OP_SET   = 2'h1,
      MASK_OP_CLEAR = 2'h2
   } oamd_mask_op_t;

   // ********************************
   // values
   // ********************************
   localparam logic [1:0]  MASK_LVL_SET   = 2'h3;
   localparam logic [1:0]  MASK_LVL_CLEAR = 2'h0;
   localparam logic [1:0]  MASK_LVL_RST   = 2'h3;
   localparam logic [7:0]  PAGE_ZERO_HI   = 8'h00;
   localparam logic [2:0]  LEN_OPCODE     = 3'h1;
   localparam logic [15:0] STEP_ONE       = 16'h0001;
   localparam logic [15:0] STEP_TWO       = 16'h0002;

endpackage
